// *** fcd_consts.svh ***
// register map, field encodings, reset values and timing counts of the dma controller
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH
`define FCD_NUM_CH         4
`define FCD_OFS_SRC        2'h0
`define FCD_OFS_DST        2'h1
`define FCD_OFS_CNT        2'h2
`define FCD_OFS_CTL        2'h3
`define FCD_OFS_OPR        8'h40
`define FCD_CH_SPAN        8'h40
`define FCD_CTL_RST        32'h0000_0000
`define FCD_CTL_WMASK      32'h0f43_fffd
`define FCD_CTL_TE_BIT     1
`define FCD_CTL_ENDPOL_BIT 22
`define FCD_CNT_ONE        24'h00_0001
`define FCD_PSEL_MAX       4'hc
`define FCD_UNIT_B         2'h0
`define FCD_UNIT_W         2'h1
`define FCD_UNIT_L         2'h2
`define FCD_UNIT_16        2'h3
`define FCD_AM_FIX         2'h0
`define FCD_AM_INC         2'h1
`define FCD_AM_DEC         2'h2
`define FCD_SRC_AUTO       2'h0
`define FCD_SRC_EXT        2'h1
`define FCD_SRC_PER        2'h2
`define FCD_BM_CS          2'h0
`define FCD_BM_CSI         2'h1
`define FCD_BM_BURST       2'h2
`define FCD_DET_LOW        2'h0
`define FCD_DET_HIGH       2'h1
`define FCD_DET_RISE       2'h2
`define FCD_DET_FALL       2'h3
`define FCD_CLK_NS         20
`define FCD_GAP_NS         160
`define FCD_GAP_CYC        ((`FCD_GAP_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`endif

// *** fcd_pkg.sv ***
// types shared by the dma controller modules
package fcd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_GAP} fcd_state_t;

  // channel control word, msb first
  typedef struct packed {
    logic [3:0] rsv_hi;
    logic [3:0] psel;
    logic       rsv_23;
    logic       end_pol;
    logic [3:0] rsv_mid;
    logic       ack_pol;
    logic [1:0] detect;
    logic [1:0] bus_mode;
    logic [1:0] req_src;
    logic       dev_to_mem;
    logic       single;
    logic [1:0] dst_mode;
    logic [1:0] src_mode;
    logic [1:0] unit;
    logic       ie;
    logic       te;
    logic       en;
  } fcd_ctl_t;

  // one memory access issued by the engine
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fcd_mem_cmd_t;
endpackage : fcd_pkg

// *** fcd_req_detect.sv ***
// external request synchroniser with level and edge detection
`timescale 1ns/1ps
`include "fcd_consts.svh"
module fcd_req_detect (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       req_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       take_in,
  output logic            req_out
);
  logic       sync0;
  logic       sync1;
  logic       prev;
  logic [2:0] primed;
  logic       pend;
  logic       edge_hit;

  // two-flop synchroniser, then one more stage for edge compare
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      sync0  <= 1'b0;
      sync1  <= 1'b0;
      prev   <= 1'b0;
      primed <= 3'h0;
    end
    else
    begin
      sync0  <= req_in;
      sync1  <= sync0;
      prev   <= sync1;
      primed <= {primed[1:0], 1'b1};
    end

  // primed keeps the reset value of the chain from faking an edge
  assign edge_hit = primed[2] &&
                    ((mode_in == `FCD_DET_RISE && sync1 && !prev) ||
                     (mode_in == `FCD_DET_FALL && !sync1 && prev));

  // edge latch: a new edge in the cycle the engine takes it still counts
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      pend <= 1'b0;
    else if (edge_hit)
      pend <= 1'b1;
    else if (take_in)
      pend <= 1'b0;

  always_comb
    case (mode_in)
      `FCD_DET_LOW:  req_out = primed[2] && !sync1;
      `FCD_DET_HIGH: req_out = primed[2] && sync1;
      default:       req_out = pend;
    endcase
endmodule : fcd_req_detect

// *** fcd_dma_top.sv ***
// four-channel dma controller: registers, arbiter and transfer engine
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "fcd_consts.svh"
module fcd_dma_top (
  // clock and reset
  input  wire logic                 MCLK_IN,
  input  wire logic                 RST_N_IN,
  // register port
  input  wire logic [7:0]           REG_ADDR_IN,
  input  wire logic [31:0]          REG_WDATA_IN,
  input  wire logic                 REG_WR_IN,
  input  wire logic                 REG_RD_IN,
  output logic [31:0]               REG_RDATA_OUT,
  // transfer requests
  input  wire logic                 XFER_REQUEST_IN_CH0,
  input  wire logic                 XFER_REQUEST_IN_CH1,
  input  wire logic [12:0]          PERIPH_REQ_IN,
  // external strobes
  output logic                      XFER_ACK_OUT_CH0,
  output logic                      XFER_ACK_OUT_CH1,
  output logic                      XFER_END_OUT,
  // memory master
  output fcd_pkg::fcd_mem_cmd_t     MEM_CMD_OUT,
  input  wire logic [31:0]          MEM_RDATA_IN,
  input  wire logic                 MEM_DONE_IN,
  // interrupt requests
  output logic [3:0]                IRQ_OUT
);
  import fcd_pkg::*;

  localparam int NCH = `FCD_NUM_CH;

  logic [31:0] src_addr [NCH];
  logic [31:0] dst_addr [NCH];
  logic [23:0] xfer_cnt [NCH];
  fcd_ctl_t    ctl      [NCH];
  logic [31:0] blk      [4];
  logic        op_en;
  logic        op_rr;
  fcd_state_t  state;
  logic [1:0]  cur;
  logic [2:0]  beat;
  logic [1:0]  rr_ptr;
  logic [3:0]  gap_cnt;
  logic        burst_hold;
  logic [1:0]  ext_det;
  logic [3:0]  req_vec;
  logic [3:0]  rdy;
  logic [2:0]  pick_res;
  logic        start;
  logic [1:0]  next_cur;
  logic [3:0]  take;
  logic        unit_done;
  logic        cnt_end;
  logic [2:0]  last;
  logic [31:0] nxt_src;
  logic [31:0] nxt_dst;
  logic [4:0]  dec_hit;
  fcd_ctl_t    cc;
  fcd_ctl_t    nc;

  // channel registers sit at ch*16, operation register above them
  function automatic logic [4:0] decode(input logic [7:0] a);
    decode = {a < `FCD_CH_SPAN, a[5:4], a[3:2]};
  endfunction : decode

  function automatic logic [31:0] unit_step(input logic [1:0] u);
    case (u)
      `FCD_UNIT_B: unit_step = 32'h1;
      `FCD_UNIT_W: unit_step = 32'h2;
      `FCD_UNIT_L: unit_step = 32'h4;
      default:     unit_step = 32'h10;
    endcase
  endfunction : unit_step

  function automatic logic [31:0] adv(input logic [31:0] a, input logic [1:0] m,
                                      input logic [1:0] u);
    case (m)
      `FCD_AM_INC: adv = a + unit_step(u);
      `FCD_AM_DEC: adv = a - unit_step(u);
      default:     adv = a;
    endcase
  endfunction : adv

  // first ready channel at or after the start index
  function automatic logic [2:0] pick(input logic [3:0] r, input logic [1:0] s);
    logic [1:0] k;
    pick = 3'h0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      k = s + 2'(i);
      if (r[k])
        pick = {1'b1, k};
    end
  endfunction : pick

  // external request detectors for the two pin channels
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ext
      fcd_req_detect i_fcd_req_detect (
        .clk_in   (MCLK_IN),
        .rst_n_in (RST_N_IN),
        .req_in   (g == 0 ? XFER_REQUEST_IN_CH0 : XFER_REQUEST_IN_CH1),
        .mode_in  (ctl[g].detect),
        .take_in  (take[g]),
        .req_out  (ext_det[g])
      );
    end
  endgenerate

  // request source per channel; only channels 0 and 1 see pins
  always_comb
    for (int i = 0; i < NCH; i++)
    begin
      case (ctl[i].req_src)
        `FCD_SRC_AUTO: req_vec[i] = 1'b1;
        `FCD_SRC_EXT:  req_vec[i] = (i < 2) && ext_det[i[0]];
        `FCD_SRC_PER:  req_vec[i] = (ctl[i].psel <= `FCD_PSEL_MAX) &&
                                    PERIPH_REQ_IN[ctl[i].psel];
        default:       req_vec[i] = 1'b0;
      endcase
      rdy[i] = op_en && ctl[i].en && !ctl[i].te && req_vec[i];
    end

  // arbitration: burst keeps the bus, else fixed or rotating priority
  assign pick_res = pick(rdy, op_rr ? rr_ptr : 2'h0);
  assign start    = (state == ST_IDLE) && (pick_res[2] || (burst_hold && rdy[cur]));
  assign next_cur = (burst_hold && rdy[cur]) ? cur : pick_res[1:0];
  assign take     = start ? (4'h1 << next_cur) : 4'h0;
  assign cc       = ctl[cur];
  assign nc       = ctl[next_cur];
  assign last     = (cc.unit == `FCD_UNIT_16) ? 3'h3 : 3'h0;
  assign cnt_end  = (xfer_cnt[cur] == `FCD_CNT_ONE);
  assign unit_done = MEM_DONE_IN && ((state == ST_RD && cc.single) ||
                     (state == ST_WR && (cc.single || beat == last)));
  assign nxt_src  = adv(src_addr[cur], cc.src_mode, cc.unit);
  assign nxt_dst  = adv(dst_addr[cur], cc.dst_mode, cc.unit);
  assign dec_hit  = decode(REG_ADDR_IN);

  // address and count: no reset, engine wins over a software write
  always_ff @(posedge MCLK_IN)
    for (int i = 0; i < NCH; i++)
    begin
      if (unit_done && cur == 2'(i))
      begin
        if (!cc.single || !cc.dev_to_mem)
          src_addr[i] <= nxt_src;
        if (!cc.single || cc.dev_to_mem)
          dst_addr[i] <= nxt_dst;
        xfer_cnt[i] <= xfer_cnt[i] - 24'h1;
      end
      else if (REG_WR_IN && dec_hit[4] && dec_hit[3:2] == 2'(i))
      begin
        case (dec_hit[1:0])
          `FCD_OFS_SRC: src_addr[i] <= REG_WDATA_IN;
          `FCD_OFS_DST: dst_addr[i] <= REG_WDATA_IN;
          `FCD_OFS_CNT: xfer_cnt[i] <= REG_WDATA_IN[23:0];
          default: ;
        endcase
      end
    end

  // control words; end flag set wins over a software clear
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      for (int i = 0; i < NCH; i++)
        ctl[i] <= `FCD_CTL_RST;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (REG_WR_IN && dec_hit[4] && dec_hit[3:2] == 2'(i) &&
            dec_hit[1:0] == `FCD_OFS_CTL)
        begin
          ctl[i] <= (REG_WDATA_IN & `FCD_CTL_WMASK &
                     ~((i == 0) ? 32'h0 : (32'h1 << `FCD_CTL_ENDPOL_BIT))) |
                    (32'(ctl[i].te & REG_WDATA_IN[`FCD_CTL_TE_BIT]) << `FCD_CTL_TE_BIT);
        end
        if (unit_done && cnt_end && cur == 2'(i))
          ctl[i].te <= 1'b1;
      end
    end

  // operation register: master enable and priority mode
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      op_en <= 1'b0;
      op_rr <= 1'b0;
    end
    else if (REG_WR_IN && REG_ADDR_IN == `FCD_OFS_OPR)
    begin
      op_en <= REG_WDATA_IN[0];
      op_rr <= REG_WDATA_IN[1];
    end

  // rotating pointer: the channel just granted drops to last place
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      rr_ptr <= 2'h0;
    else if (start)
      rr_ptr <= next_cur + 2'h1;

  // block buffer for four-longword units
  always_ff @(posedge MCLK_IN)
    if (state == ST_RD && MEM_DONE_IN)
      blk[beat[1:0]] <= MEM_RDATA_IN;

  // transfer engine
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      state            <= ST_IDLE;
      cur              <= 2'h0;
      beat             <= 3'h0;
      gap_cnt          <= 4'h0;
      burst_hold       <= 1'b0;
      MEM_CMD_OUT      <= '0;
      XFER_ACK_OUT_CH0 <= 1'b1;
      XFER_ACK_OUT_CH1 <= 1'b1;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          XFER_ACK_OUT_CH0 <= !ctl[0].ack_pol;
          XFER_ACK_OUT_CH1 <= !ctl[1].ack_pol;
          if (start)
          begin
            cur   <= next_cur;
            beat  <= 3'h0;
            state <= (nc.single && nc.dev_to_mem) ? ST_WR : ST_RD;
            MEM_CMD_OUT.req   <= 1'b1;
            MEM_CMD_OUT.we    <= nc.single && nc.dev_to_mem;
            MEM_CMD_OUT.size  <= (nc.unit == `FCD_UNIT_16) ? `FCD_UNIT_L : nc.unit;
            MEM_CMD_OUT.addr  <= (nc.single && nc.dev_to_mem) ? dst_addr[next_cur] :
                                 src_addr[next_cur];
            MEM_CMD_OUT.wdata <= 32'h0;
            if (nc.req_src == `FCD_SRC_EXT && next_cur == 2'h0)
              XFER_ACK_OUT_CH0 <= ctl[0].ack_pol;
            if (nc.req_src == `FCD_SRC_EXT && next_cur == 2'h1)
              XFER_ACK_OUT_CH1 <= ctl[1].ack_pol;
          end
        end
        ST_RD:
          if (MEM_DONE_IN && !cc.single)
          begin
            if (beat == last)
            begin
              beat              <= 3'h0;
              state             <= ST_WR;
              MEM_CMD_OUT.we    <= 1'b1;
              MEM_CMD_OUT.addr  <= dst_addr[cur];
              MEM_CMD_OUT.wdata <= (beat == 3'h0) ? MEM_RDATA_IN : blk[0];
            end
            else
            begin
              beat             <= beat + 3'h1;
              MEM_CMD_OUT.addr <= src_addr[cur] + {27'h0, beat + 3'h1, 2'b00};
            end
          end
        ST_WR:
          if (MEM_DONE_IN && !unit_done)
          begin
            beat              <= beat + 3'h1;
            MEM_CMD_OUT.addr  <= dst_addr[cur] + {27'h0, beat + 3'h1, 2'b00};
            // all four longwords sit in the block buffer by now; the bus
            // data during a write beat is not the block's data
            MEM_CMD_OUT.wdata <= blk[2'(beat + 3'h1)];
          end
        ST_GAP:
        begin
          // intermittent mode keeps the bus idle for a fixed gap; no channel can start until it ends
          gap_cnt <= gap_cnt - 4'h1;
          if (gap_cnt == 4'h1)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (unit_done)
      begin
        MEM_CMD_OUT.req  <= 1'b0;
        MEM_CMD_OUT.we   <= 1'b0;
        XFER_ACK_OUT_CH0 <= !ctl[0].ack_pol;
        XFER_ACK_OUT_CH1 <= !ctl[1].ack_pol;
        burst_hold       <= (cc.bus_mode == `FCD_BM_BURST) && !cnt_end;
        gap_cnt          <= 4'(`FCD_GAP_CYC);
        state <= (cc.bus_mode == `FCD_BM_CSI && !cnt_end) ? ST_GAP : ST_IDLE;
      end
    end

  // end strobe for channel 0, one cycle at its programmed level
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      XFER_END_OUT <= 1'b1;
    else if (unit_done && cnt_end && cur == 2'h0)
      XFER_END_OUT <= ctl[0].end_pol;
    else
      XFER_END_OUT <= !ctl[0].end_pol;

  // interrupt level per channel while the end flag stands and ie is set
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      IRQ_OUT <= 4'h0;
    else
      for (int i = 0; i < NCH; i++)
        IRQ_OUT[i] <= ctl[i].te && ctl[i].ie;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      REG_RDATA_OUT <= 32'h0;
    else if (!REG_RD_IN)
      REG_RDATA_OUT <= 32'h0;
    else if (REG_ADDR_IN == `FCD_OFS_OPR)
      REG_RDATA_OUT <= {24'h0, (state != ST_IDLE) ? (4'h1 << cur) : 4'h0,
                        2'h0, op_rr, op_en};
    else if (dec_hit[4])
      case (dec_hit[1:0])
        `FCD_OFS_SRC: REG_RDATA_OUT <= src_addr[dec_hit[3:2]];
        `FCD_OFS_DST: REG_RDATA_OUT <= dst_addr[dec_hit[3:2]];
        `FCD_OFS_CNT: REG_RDATA_OUT <= {8'h0, xfer_cnt[dec_hit[3:2]]};
        default:      REG_RDATA_OUT <= ctl[dec_hit[3:2]];
      endcase
    else
      REG_RDATA_OUT <= 32'h0;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence seq_last_read;
    state == ST_RD && MEM_DONE_IN && !cc.single && beat == last;
  endsequence
  sequence seq_write_issued;
    state == ST_WR && MEM_CMD_OUT.req && MEM_CMD_OUT.we && beat == 3'h0;
  endsequence

  chk_cnt_top_zero: assert property (
    REG_RD_IN && dec_hit[4] && dec_hit[1:0] == `FCD_OFS_CNT |=> REG_RDATA_OUT[31:24] == 8'h0)
    else $error("count top byte not zero");
  chk_cnt_step: assert property (
    unit_done |=> xfer_cnt[cur] == $past(xfer_cnt[cur]) - 24'h1)
    else $error("count not decremented by one");
  chk_end_flag: assert property (
    unit_done && cnt_end |=> ctl[cur].te)
    else $error("end flag missing at last transfer");
  chk_end_pulse: assert property (
    unit_done && cnt_end && cur == 2'h0 |=> XFER_END_OUT == ctl[0].end_pol
      ##1 XFER_END_OUT == !ctl[0].end_pol)
    else $error("end strobe wrong");
  chk_ack_strobe: assert property (
    MEM_CMD_OUT.req && cur == 2'h0 && ctl[0].req_src == `FCD_SRC_EXT
      |-> XFER_ACK_OUT_CH0 == ctl[0].ack_pol)
    else $error("ack not active during access");
  chk_block_beats: assert property (
    unit_done && !cc.single && cc.unit == `FCD_UNIT_16 |-> beat == 3'h3)
    else $error("block ended before four longwords");
  chk_read_then_write: assert property (
    seq_last_read |=> seq_write_issued)
    else $error("write not issued after reads");
  chk_rr_rotate: assert property (
    start && op_rr |=> rr_ptr == $past(next_cur) + 2'h1)
    else $error("round robin pointer wrong");
  chk_fixed_prio: assert property (
    start && !op_rr && !burst_hold && rdy[0] |=> cur == 2'h0)
    else $error("fixed priority violated");
  chk_single_src: assert property (
    unit_done && cc.single && cc.dev_to_mem |=> $stable(src_addr[cur]))
    else $error("source moved in single mode");
endmodule : fcd_dma_top

// *** fcd_ext_dev.sv ***
// far-side model: memory slave with a set latency and one requesting external device
`timescale 1ns/1ps
module fcd_ext_dev (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // memory side
  input  wire fcd_pkg::fcd_mem_cmd_t cmd_in,
  input  wire logic [3:0]            lat_in,
  output logic [31:0]                rdata_out,
  output logic                       done_out,
  // external device side
  input  wire logic                  go_in,
  input  wire logic                  ack_in,
  output logic                       req_out
);
  import fcd_pkg::*;

  logic [3:0]  cnt;
  logic [64:0] log_q[$];

  // one done pulse per beat after lat_in waits; read data keeps toggling off the beat
  // so a sample taken at the wrong cycle never looks right by chance
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt       <= 4'h0;
      done_out  <= 1'b0;
      rdata_out <= 32'h0;
    end
    else if (done_out)
    begin
      cnt       <= 4'h0;
      done_out  <= 1'b0;
      rdata_out <= ~rdata_out;
    end
    else if (cmd_in.req && cnt == lat_in)
    begin
      done_out  <= 1'b1;
      rdata_out <= ~cmd_in.addr;
      log_q.push_back({cmd_in.we, cmd_in.addr, cmd_in.wdata});
    end
    else
    begin
      cnt       <= cmd_in.req ? cnt + 4'h1 : 4'h0;
      rdata_out <= ~rdata_out;
    end
  end

  // raise the request on go and drop it once the strobe answers
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      req_out <= 1'b0;
    else if (ack_in)
      req_out <= 1'b0;
    else if (go_in)
      req_out <= 1'b1;
  end
endmodule : fcd_ext_dev

// *** fcd_dma_top_tb.sv ***
// self-checking bench for the four-channel dma controller
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] %s exp %h got %h", nm, exp, got); \
    end \
  end
module fcd_dma_top_tb;
  import fcd_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} fcd_row_t;

  logic         clk;
  logic         rst_n;
  logic [7:0]   addr;
  logic [31:0]  wdata;
  logic         wr;
  logic         rd;
  logic [31:0]  rdata;
  logic         req1;
  logic         ack0;
  logic         ack1;
  logic         xend;
  fcd_mem_cmd_t cmd;
  logic [31:0]  mrdata;
  logic         mdone;
  logic [3:0]   irq;
  logic [3:0]   lat;
  logic         go;
  logic         end_q;
  logic [31:0]  v;
  int           n_end;
  int           n_ackdone;
  int           n_mismatch;
  int           num_checks;
  int           cyc;
  // register rows: written value and what a read must give back
  fcd_row_t rows [6] = '{'{8'h00, 32'hffff_fffc, 32'hffff_fffc},
                         '{8'h14, 32'h0000_0002, 32'h0000_0002},
                         '{8'h28, 32'hff00_0001, 32'h0000_0001},
                         '{8'h38, 32'hffff_ffff, 32'h00ff_ffff},
                         '{8'h3c, 32'h0000_0000, 32'h0000_0000},
                         '{8'h44, 32'hdead_beef, 32'h0000_0000}};

  // external request of channel 0 and peripheral requests are held idle
  fcd_dma_top i_fcd_dma_top (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .XFER_REQUEST_IN_CH0(1'b0), .XFER_REQUEST_IN_CH1(req1), .PERIPH_REQ_IN(13'h0),
    .XFER_ACK_OUT_CH0(ack0), .XFER_ACK_OUT_CH1(ack1), .XFER_END_OUT(xend),
    .MEM_CMD_OUT(cmd), .MEM_RDATA_IN(mrdata), .MEM_DONE_IN(mdone), .IRQ_OUT(irq));

  fcd_ext_dev i_fcd_ext_dev (
    .clk_in(clk), .rst_n_in(rst_n), .cmd_in(cmd), .lat_in(lat), .rdata_out(mrdata),
    .done_out(mdone), .go_in(go), .ack_in(ack1), .req_out(req1));

  // clock of 20 ns
  always #10 clk = ~clk;

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe is taken
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    `CHK("register read", e, rdata)
  endtask : chk_reg

  // bounded wait for n logged beats and the command released
  task automatic wait_beats(input int n);
    int k;
    k = 0;
    while ((i_fcd_ext_dev.log_q.size() < n || cmd.req) && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (2) @(posedge clk);
  endtask : wait_beats

  // compare the oldest logged beat; write data only matters on writes
  task automatic beat(input logic we, input logic [31:0] a, input logic [31:0] d);
    logic [64:0] b;
    b = 'x;
    if (i_fcd_ext_dev.log_q.size() != 0)
      b = i_fcd_ext_dev.log_q.pop_front();
    `CHK("beat kind and address", {we, a}, b[64:32])
    if (we)
      `CHK("beat write data", d, b[31:0])
  endtask : beat

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // end pulses and strobed beats seen on the pins, plus the hang limit
  always @(posedge clk)
  begin
    end_q <= xend;
    if (xend && !end_q)
      n_end++;
    if (mdone && ack1)
      n_ackdone++;
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    clk = 1'b0; rst_n = 1'b0; addr = 8'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    lat = 4'h0; go = 1'b0; end_q = 1'b0; n_end = 0; n_ackdone = 0;
    n_mismatch = 0; num_checks = 0; cyc = 0;
    repeat (10) @(posedge clk);
    #1;
    `CHK("reset outputs", {32'h0, 3'b111, 68'h0, 4'h0}, {rdata, ack0, ack1, xend, cmd, irq})
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].w);
      chk_reg(rows[i].a, rows[i].e);
    end
    wr_reg(8'h40, 32'h0000_0001);
    // channel 0: dual longword, two units, burst, prompt memory, end pulse active high
    wr_reg(8'h00, 32'hffff_ff00);
    wr_reg(8'h04, 32'h8000_0010);
    wr_reg(8'h08, 32'h0000_0002);
    n_end = 0;
    wr_reg(8'h0c, 32'h0040_40b5);
    wait_beats(4);
    for (int k = 0; k < 2; k++)
    begin
      beat(1'b0, 32'hffff_ff00 + 4 * k, 32'h0);
      beat(1'b1, 32'h8000_0010 + 4 * k, ~(32'hffff_ff00 + 4 * k));
    end
    chk_reg(8'h00, 32'hffff_ff08);
    chk_reg(8'h04, 32'h8000_0018);
    chk_reg(8'h08, 32'h0000_0000);
    `CHK("end pulses", 1, n_end)
    `CHK("irq", 4'b0001, irq)
    // channel 2: one 16-byte unit against slow memory
    lat = 4'h5;
    n_end = 0;
    wr_reg(8'h20, 32'h0000_1000);
    wr_reg(8'h24, 32'h0000_2000);
    wr_reg(8'h28, 32'h0000_0001);
    wr_reg(8'h2c, 32'h0000_00bd);
    wait_beats(8);
    for (int k = 0; k < 4; k++)
      beat(1'b0, 32'h0000_1000 + 4 * k, 32'h0);
    for (int k = 0; k < 4; k++)
      beat(1'b1, 32'h0000_2000 + 4 * k, ~(32'h0000_1000 + 4 * k));
    chk_reg(8'h20, 32'h0000_1010);
    chk_reg(8'h24, 32'h0000_2010);
    chk_reg(8'h28, 32'h0000_0000);
    `CHK("end pulses", 0, n_end)
    `CHK("irq", 4'b0101, irq)
    // channel 1: external request, single address device to memory, count zero
    lat = 4'h4;
    wr_reg(8'h10, 32'h1234_5670);
    wr_reg(8'h14, 32'h3000_0000);
    wr_reg(8'h18, 32'h0000_0000);
    wr_reg(8'h1c, 32'h0002_8e95);
    n_ackdone = 0;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_beats(1);
    beat(1'b1, 32'h3000_0000, 32'h0);
    chk_reg(8'h10, 32'h1234_5670);
    chk_reg(8'h14, 32'h3000_0004);
    chk_reg(8'h18, 32'h00ff_ffff);
    `CHK("strobed beats", 1, n_ackdone)
    `CHK("irq", 4'b0101, irq)
    close_out();
  end
endmodule : fcd_dma_top_tb
